// *** isw_switch.sv ***
`include "isw_cfg.svh"
`default_nettype none
module isw_switch import isw_pkg::*; #(
    parameter int DATA_W = `ISW_DATA_WIDTH,
    parameter int START_CYCLES = `ISW_START_CYCLES,
    parameter int WAKE_CYCLES = `ISW_WAKE_CYCLES,
    parameter int CONV_SENSOR_CYCLES = `ISW_CONV_SENSOR_CYCLES,
    parameter int TICK_TIMEOUT = `ISW_TICK_TIMEOUT_CYCLES,
    parameter logic [DATA_W-1:0] OFFSET_STEP = 'h10
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic enable_in,
    input wire logic sensor_tick_in,
    input wire logic [DATA_W-1:0] sense_coil_input_in,
    input wire logic [DATA_W-1:0] reference_coil_input_in,
    input wire logic [`ISW_ADJ_WIDTH-1:0] threshold_adjust_input_in,
    output logic switch_out,
    output logic active_out,
    output logic fault_out
);
    localparam int PW = DATA_W + 9;
    localparam int SCW = $clog2(CONV_SENSOR_CYCLES + 1);
    localparam int TW = $clog2(((START_CYCLES > WAKE_CYCLES) ? START_CYCLES : WAKE_CYCLES) + 1);
    localparam int WW = $clog2(TICK_TIMEOUT + 1);

    // two-stage synchronisers for every pin but reset_in; first stage is read only by the second
    logic en_s1, en_s2, tick_s1, tick_s2, tick_d;
    logic [DATA_W-1:0] sen_s1, sen_s2, ref_s1, ref_s2;
    logic [`ISW_ADJ_WIDTH-1:0] adj_s1, adj_s2;
    logic [DATA_W-1:0] sen_s3, ref_s3, sen_h, ref_h;
    logic [`ISW_ADJ_WIDTH-1:0] adj_s3, adj_h;

    always_ff @(posedge clk_in) begin
        en_s1 <= enable_in;
        en_s2 <= en_s1;
        tick_s1 <= sensor_tick_in;
        tick_s2 <= tick_s1;
        tick_d <= tick_s2;
        sen_s1 <= sense_coil_input_in;
        sen_s2 <= sen_s1;
        ref_s1 <= reference_coil_input_in;
        ref_s2 <= ref_s1;
        adj_s1 <= threshold_adjust_input_in;
        adj_s2 <= adj_s1;
    end

    wire tick_rise = tick_s2 & ~tick_d;

    // a word moving through the synchroniser can be caught half old and half new;
    // it is only taken once two successive synchronised samples agree
    wire sen_steady = (sen_s2 == sen_s3);
    wire ref_steady = (ref_s2 == ref_s3);
    wire adj_steady = (adj_s2 == adj_s3);

    // costs two clocks of latency, far below one conversion
    always_ff @(posedge clk_in) begin
        sen_s3 <= sen_s2;
        ref_s3 <= ref_s2;
        adj_s3 <= adj_s2;
        if (sen_steady) begin
            sen_h <= sen_s3;
        end
        if (ref_steady) begin
            ref_h <= ref_s3;
        end
        if (adj_steady) begin
            adj_h <= adj_s3;
        end
    end

    isw_state_t state, next_state;
    logic [TW-1:0] wait_cnt;
    logic [SCW-1:0] conv_cnt;
    logic [WW-1:0] wdog_cnt;

    // comparison path
    wire adj_mode = (adj_h != '0);
    wire [DATA_W+`ISW_ADJ_WIDTH-1:0] offset_full = adj_h * OFFSET_STEP;
    // the offset is clipped to the reference so the subtraction cannot wrap
    wire [DATA_W-1:0] offset = (offset_full > {{`ISW_ADJ_WIDTH{1'b0}}, ref_h}) ? ref_h :
                               offset_full[DATA_W-1:0];
    wire [DATA_W-1:0] ref_eff = adj_mode ? (ref_h - offset) : ref_h;
    wire [PW-1:0] sen_scaled = PW'(sen_h) * PW'(`ISW_HYST_DEN);
    wire [PW-1:0] ref_on = PW'(ref_eff) * PW'(`ISW_HYST_ON_NUM);
    wire [PW-1:0] ref_off = PW'(ref_eff) * PW'(`ISW_HYST_OFF_NUM);
    wire below_on = sen_scaled < ref_on;
    wire above_off = sen_scaled > ref_off;

    // open coil reads as zero, shorted or saturated coil as all ones; silent oscillator too
    wire word_bad = (sen_h == '0) || (ref_h == '0) || (&sen_h) || (&ref_h);
    wire osc_dead = (wdog_cnt == WW'(TICK_TIMEOUT));
    wire sensor_bad = word_bad | osc_dead;
    wire wait_done = (wait_cnt == '0);
    wire conv_done = tick_rise && (conv_cnt == SCW'(CONV_SENSOR_CYCLES - 1));

    always_comb begin
        next_state = state;
        case (state)
            ISW_TEST: begin
                // the test runs to completion whatever enable does
                if (wait_done) begin
                    if (sensor_bad) begin
                        next_state = ISW_FAULT;
                    end else if (en_s2) begin
                        next_state = ISW_CONVERT;
                    end else begin
                        next_state = ISW_SHUTDOWN;
                    end
                end
            end
            ISW_SHUTDOWN: begin
                if (en_s2) begin
                    next_state = ISW_WAKE;
                end
            end
            ISW_WAKE: begin
                if (!en_s2) begin
                    next_state = ISW_SHUTDOWN;
                end else if (wait_done) begin
                    next_state = sensor_bad ? ISW_FAULT : ISW_CONVERT;
                end
            end
            ISW_CONVERT: begin
                if (!en_s2) begin
                    next_state = ISW_SHUTDOWN;
                end else if (sensor_bad) begin
                    next_state = ISW_FAULT;
                end
            end
            ISW_FAULT: begin
                // a fault is left only through shutdown, which re-runs the wake check
                if (!en_s2) begin
                    next_state = ISW_SHUTDOWN;
                end
            end
            default: begin
                next_state = ISW_TEST;
            end
        endcase
    end

    wire entering_wake = (state != ISW_WAKE) && (next_state == ISW_WAKE);
    wire in_measure = (state == ISW_CONVERT);

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            state <= ISW_TEST;
            wait_cnt <= TW'(START_CYCLES - 1);
        end else begin
            state <= next_state;
            if (entering_wake) begin
                wait_cnt <= TW'(WAKE_CYCLES - 1);
            end else if (!wait_done) begin
                wait_cnt <= wait_cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in || !in_measure) begin
            conv_cnt <= '0;
        end else if (tick_rise) begin
            conv_cnt <= conv_done ? '0 : (conv_cnt + 1'b1);
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in || state == ISW_SHUTDOWN || tick_rise) begin
            wdog_cnt <= '0;
        end else if (!osc_dead) begin
            wdog_cnt <= wdog_cnt + 1'b1;
        end
    end

    // the switch starts high and only a finished conversion can pull it low
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            switch_out <= 1'b1;
        end else if (!in_measure || sensor_bad) begin
            switch_out <= 1'b1;
        end else if (conv_done) begin
            if (below_on) begin
                switch_out <= 1'b0;
            end else if (above_off) begin
                switch_out <= 1'b1;
            end
            // inside the band the previous state stands
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            active_out <= 1'b0;
            fault_out <= 1'b0;
        end else begin
            active_out <= (next_state == ISW_CONVERT);
            fault_out <= (next_state == ISW_FAULT);
        end
    end
endmodule : isw_switch
`default_nettype wire

// *** isw_cfg.svh ***
// Functional notes
// - output low when sense inductance below reference, high when sense exceeds reference
// - switch on below ratio 99.6 percent, switch off above 100.4 percent
// - adjust code zero is basic mode: no offset, switch at equal inductance
// - adjust mode subtracts an offset inductance from reference before comparing
// - codes 1 to 15; offset linear in code, distance follows 1 - code/16
// - conversion spans a fixed sensor cycle count; output updated at its end
// - after power-up the output stays high until the sensor test completes
// - output stays high during the power-up test even with enable low
// - a sensor fault (open or damaged coil) holds the output high
// - enable low enters shutdown, stops conversions, output held high
// - enable high enters active mode and resumes measuring both coils
// - shutdown to active takes 450 us; active to shutdown under 1 us
// - output delay about 580 us, two 290 us conversions at 15 MHz
`ifndef ISW_CFG_SVH
`define ISW_CFG_SVH

`define ISW_CLK_PERIOD_PS 25000
`define ISW_WAKE_TIME_US 450
`define ISW_START_TIME_US 450
`define ISW_SHUTDOWN_TIME_US 1
`define ISW_WAKE_CYCLES ((`ISW_WAKE_TIME_US * 1000000 + `ISW_CLK_PERIOD_PS - 1) / `ISW_CLK_PERIOD_PS)
`define ISW_START_CYCLES ((`ISW_START_TIME_US * 1000000 + `ISW_CLK_PERIOD_PS - 1) / `ISW_CLK_PERIOD_PS)
// 1 / 231.0e-6 sensor cycles per conversion, rounded to a whole count
`define ISW_CONV_RATE_E7 2310
`define ISW_CONV_SENSOR_CYCLES ((10000000 + `ISW_CONV_RATE_E7 / 2) / `ISW_CONV_RATE_E7)
// hysteresis as sense*den against ref*num: 249/250 = 99.6 %, 251/250 = 100.4 %
`define ISW_HYST_DEN 250
`define ISW_HYST_ON_NUM 249
`define ISW_HYST_OFF_NUM 251
`define ISW_ADJ_STEPS 16
`define ISW_TICK_TIMEOUT_CYCLES 4000
`define ISW_DATA_WIDTH 16
`define ISW_ADJ_WIDTH 4

`endif

// *** isw_pkg.sv ***
`default_nettype none
package isw_pkg;
    typedef enum logic [2:0] {
        ISW_TEST = 3'h0,
        ISW_SHUTDOWN = 3'h1,
        ISW_WAKE = 3'h3,
        ISW_CONVERT = 3'h2,
        ISW_FAULT = 3'h6
    } isw_state_t;
endpackage : isw_pkg
`default_nettype wire

// *** isw_coil_model.sv ***
`default_nettype none
module isw_coil_model (
    input wire logic [15:0] sense_val_in,
    input wire logic [15:0] ref_val_in,
    input wire logic open_in,
    output logic tick_out,
    output logic [15:0] sense_out,
    output logic [15:0] ref_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // lc tank runs free; 74 ns drifts against the 25 ns clock on purpose
    initial tick_out = 1'b0;
    always #37 tick_out = ~tick_out;
    // a broken coil reads as zero inductance
    assign sense_out = open_in ? 16'h0000 : sense_val_in;
    assign ref_out = ref_val_in;
endmodule : isw_coil_model
`default_nettype wire

// *** isw_switch_props.sv ***
`default_nettype none
module isw_switch_props #(parameter int START_CYCLES = 20, parameter int WAKE_CYCLES = 20) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic enable_in,
    input wire logic switch_out,
    input wire logic active_out,
    input wire logic fault_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int start_cnt;
    int en_cnt;
    // counters saturate so long runs cannot wrap
    always_ff @(posedge clk_in) begin
        start_cnt <= reset_in ? 0 : start_cnt + int'(start_cnt < START_CYCLES);
        en_cnt <= !enable_in ? 0 : en_cnt + int'(en_cnt < WAKE_CYCLES);
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    sequence en_low_s; !enable_in [*5]; endsequence
    sequence idle_s; !active_out [*3]; endsequence
    reset_high_a: assert property (disable iff (1'b0) reset_in |=> switch_out && !active_out && !fault_out)
        else $error("outputs busy after reset");
    start_hold_a: assert property (start_cnt < START_CYCLES |-> switch_out && !fault_out) else $error("early");
    shutdown_a: assert property (en_low_s |-> !active_out && switch_out) else $error("no shutdown");
    idle_high_a: assert property (idle_s |-> switch_out) else $error("idle output low");
    fall_active_a: assert property ($fell(switch_out) |-> active_out && !fault_out) else $error("bad on");
    fault_high_a: assert property (fault_out ##1 fault_out |-> switch_out && !active_out) else $error("fault on");
    fault_exit_a: assert property ($fell(fault_out) |-> !$past(enable_in, 2)) else $error("fault left");
    wake_time_a: assert property ($rose(active_out) |-> en_cnt >= WAKE_CYCLES) else $error("short wake");
endmodule : isw_switch_props
bind isw_switch isw_switch_props #(.START_CYCLES(START_CYCLES), .WAKE_CYCLES(WAKE_CYCLES)) isw_switch_props_inst (
    .clk_in(clk_in), .reset_in(reset_in), .enable_in(enable_in),
    .switch_out(switch_out), .active_out(active_out), .fault_out(fault_out));
`default_nettype wire

// *** tb.sv ***
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DLY = 70;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic enable_in = 1'b0;
    logic open_coil = 1'b0;
    logic [15:0] sense_val = 16'h0384;
    logic [15:0] ref_val = 16'h03e8;
    logic [3:0] code = 4'h0;
    logic tick, sw, act, flt;
    logic [15:0] sense_w, ref_w;
    int miscompares = 0;
    int compares = 0;
    int cycles = 0;
    always #12.5 clk_in = ~clk_in;
    isw_coil_model isw_coil_model_inst (.sense_val_in(sense_val), .ref_val_in(ref_val), .open_in(open_coil),
        .tick_out(tick), .sense_out(sense_w), .ref_out(ref_w));
    isw_switch #(.START_CYCLES(20), .WAKE_CYCLES(20), .CONV_SENSOR_CYCLES(8), .TICK_TIMEOUT(50)) isw_switch_inst (
        .clk_in(clk_in), .reset_in(reset_in), .enable_in(enable_in), .sensor_tick_in(tick),
        .sense_coil_input_in(sense_w), .reference_coil_input_in(ref_w), .threshold_adjust_input_in(code),
        .switch_out(sw), .active_out(act), .fault_out(flt));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic run(input int n);
        repeat (n) @(negedge clk_in);
    endtask : run
    task automatic end_sim;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim
    // the output is only trusted after wake time plus two conversions
    task automatic wake;
        enable_in = 1'b1;
        run(18);
        check(16'(act), 16'h0);
        run(12);
        check(16'(act), 16'h1);
        run(DLY);
    endtask : wake
    task automatic t_powerup;
        run(16);
        reset_in = 1'b0;
        for (int i = 0; i < 30; i++) begin
            run(1);
            check(16'(sw), 16'h1);
        end
        wake();
        check(16'(sw), 16'h0);
        $display("end powerup");
    endtask : t_powerup
    task automatic t_hyst;
        logic [15:0] sv [4] = '{16'h03eb, 16'h03ed, 16'h03e5, 16'h03e3};
        logic [15:0] ex [4] = '{16'h0, 16'h1, 16'h1, 16'h0};
        for (int i = 0; i < 4; i++) begin
            sense_val = sv[i];
            run(DLY);
            check(16'(sw), ex[i]);
        end
        $display("end hysteresis");
    endtask : t_hyst
    task automatic t_adjust;
        int r;
        for (int c = 0; c < 16; c++) begin
            r = 1000 - c * 16;
            code = 4'(c);
            sense_val = 16'(r - 8);
            run(DLY);
            check(16'(sw), 16'h0);
            sense_val = 16'(r + 8);
            run(DLY);
            check(16'(sw), 16'h1);
        end
        $display("end adjust");
    endtask : t_adjust
    task automatic t_shut_fault;
        code = 4'h0;
        sense_val = 16'h0384;
        run(DLY);
        enable_in = 1'b0;
        run(5);
        check(16'(sw), 16'h1);
        wake();
        open_coil = 1'b1;
        run(DLY);
        check(16'({flt, sw}), 16'h3);
        open_coil = 1'b0;
        enable_in = 1'b0;
        run(6);
        check(16'({flt, sw}), 16'h1);
        wake();
        check(16'(sw), 16'h0);
        $display("end shutdown fault");
    endtask : t_shut_fault
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            end_sim();
        end
    end
    initial begin
        t_powerup();
        t_hyst();
        t_adjust();
        t_shut_fault();
        end_sim();
    end
endmodule : tb
`default_nettype wire
